/* File: src/fpcc_params.svh */
/*
 Constants of the front panel console controller.
 Assumes a 25 MHz system clock.
*/
`ifndef FPCC_PARAMS_SVH
`define FPCC_PARAMS_SVH
`define FPCC_CLK_HZ 25000000
`define FPCC_DEBOUNCE_MS 10
`define FPCC_DEBOUNCE_CYCLES ((`FPCC_CLK_HZ / 1000) * `FPCC_DEBOUNCE_MS)
`define FPCC_SLOW_HZ 2
`define FPCC_SLOW_CYCLES (`FPCC_CLK_HZ / `FPCC_SLOW_HZ)
`define FPCC_CNT_W 24
`define FPCC_SENSE_PORT 8'hFF
`define FPCC_REG_CTRL 8'h00
`define FPCC_REG_STATUS 8'h04
`define FPCC_REG_ADDR 8'h08
`define FPCC_CTRL_INSTR_BIT 0
`define FPCC_CTRL_RESET 1'h0
`define FPCC_STAT_RUN_BIT 0
`define FPCC_STAT_BUSY_BIT 1
`define FPCC_ADDR_RESET 16'h0000
`endif

/* File: src/fpcc_pkg.sv */
/*
 Types of the front panel console controller.
 Assumes fpcc_params.svh is on the include path.
*/
`include "fpcc_params.svh"
package fpcc_pkg;
    // Momentary and held panel switches, one bit each.
    typedef struct packed {
        logic run;
        logic stop;
        logic step;
        logic slow;
        logic examine;
        logic examineFollowing;
        logic deposit;
        logic depositFollowing;
        logic reset;
        logic busClearRequest;
        logic protect;
        logic unprotect;
        logic accDisplay;
        logic accLoad;
        logic ioIn;
        logic ioOut;
    } fpcc_sw_s;
    // Processor status lines, also the status lamps.
    typedef struct packed {
        logic memRead;
        logic opcodeFetch;
        logic ioIn;
        logic ioOut;
        logic halted;
        logic stack;
        logic writeCycle;
        logic irqAck;
        logic irqEnabled;
        logic waiting;
        logic holdAck;
        logic memProtected;
    } fpcc_status_s;
    // Panel sequencer states.
    typedef enum logic [2:0] {
        PS_STOP,
        PS_RUN,
        PS_ADVANCE,
        PS_READ,
        PS_CAPTURE,
        PS_WRITE
    } fpcc_state_e;
    // All state of the controller.
    typedef struct packed {
        fpcc_state_e             state;
        fpcc_sw_s                swSync1;
        fpcc_sw_s                swSync2;
        fpcc_sw_s                swStable;
        fpcc_sw_s                cmd;
        logic [15:0]             addrSync1;
        logic [15:0]             addrSync2;
        logic [`FPCC_CNT_W-1:0]  dbCnt;
        logic [`FPCC_CNT_W-1:0]  slowCnt;
        logic                    powerUp;
        logic                    stepByInstr;
        logic                    showAcc;
        logic [7:0]              dataHold;
        logic                    cpuHold;
        logic                    cpuAdvance;
        logic                    cpuReset;
        logic                    busClear;
        logic [15:0]             memAddr;
        logic [7:0]              memWrData;
        logic                    memRdStb;
        logic                    memWrStb;
        logic                    protectStb;
        logic                    unprotectStb;
        logic                    accLoadStb;
        logic [7:0]              accLoadData;
        logic                    ioInStb;
        logic                    ioOutStb;
        logic [7:0]              ioPort;
        logic [7:0]              senseData;
        logic                    senseValid;
        logic [15:0]             addrLamps;
        logic [7:0]              dataLamps;
        fpcc_status_s            statusLamps;
        logic [31:0]             regRdData;
    } fpcc_regs_s;
endpackage

/* File: src/fpcc_top.sv */
/*
 Front panel console controller: switches and lamps on one
 side, processor and system bus strobes on the other.
 Assumes processor and memory run on ref_clk; switches are
 asynchronous pins.
*/
// Chosen here: the register addresses and the address-and-strobe port.
// Summary of operation
// - Run mode ignores all but stop and reset.
// - Stop holds processor waiting, enables panel.
// - Step releases one machine or instruction cycle.
// - Slow steps about twice per second.
// - Examine reads switch address, shows byte.
// - Examine following reads next address.
// - Deposit writes low switches at address.
// - Deposit following writes at next address.
// - Reset clears counter and interrupt enable.
// - Bus clear drives clear onto bus.
// - Protect guards addressed board against writes.
// - Unprotect allows memory changes again.
// - Accumulator display shows accumulator on lamps.
// - Accumulator load copies low switches.
// - Input moves device byte into accumulator.
// - Output sends accumulator to device.
// - Switch up reads one, down zero.
// - Panel port input returns upper switches.
// - Status lamps follow processor status lines.
// - Address lamps show processor address in run, panel address otherwise.
// - Data lamps show carried byte.
// - Power-up resets processor, holds it waiting.
`timescale 1ns/1ps
`default_nettype none
`include "fpcc_params.svh"
module fpcc_top
    import fpcc_pkg::*;
#(
    parameter int unsigned DEBOUNCE_CYCLES = `FPCC_DEBOUNCE_CYCLES,
    parameter int unsigned SLOW_CYCLES     = `FPCC_SLOW_CYCLES
)(
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire fpcc_sw_s     swIn,
    input  wire logic [15:0]  addrSwIn,
    input  wire fpcc_status_s cpuStatus,
    input  wire logic         cycleStart,
    input  wire logic [15:0]  cpuAddr,
    input  wire logic [7:0]   cpuData,
    input  wire logic [7:0]   accValue,
    input  wire logic         ioRdStb,
    input  wire logic [7:0]   ioRdPort,
    input  wire logic [7:0]   memRdData,
    input  wire logic [7:0]   regAddr,
    input  wire logic [31:0]  regWrData,
    input  wire logic         regWr,
    input  wire logic         regRd,
    output wire logic [31:0]  regRdData,
    output wire logic         cpuHold,
    output wire logic         cpuAdvance,
    output wire logic         cpuReset,
    output wire logic         busClear,
    output wire logic [15:0]  memAddr,
    output wire logic [7:0]   memWrData,
    output wire logic         memRdStb,
    output wire logic         memWrStb,
    output wire logic         protectStb,
    output wire logic         unprotectStb,
    output wire logic         accLoadStb,
    output wire logic [7:0]   accLoadData,
    output wire logic         ioInStb,
    output wire logic         ioOutStb,
    output wire logic [7:0]   ioPort,
    output wire logic [7:0]   senseData,
    output wire logic         senseValid,
    output wire logic [15:0]  addrLamps,
    output wire logic [7:0]   dataLamps,
    output wire fpcc_status_s statusLamps
);
    // Last counts of the two timers, at counter width.
    localparam logic [`FPCC_CNT_W-1:0] DB_LAST =
        `FPCC_CNT_W'(DEBOUNCE_CYCLES - 1);
    localparam logic [`FPCC_CNT_W-1:0] SLOW_LAST =
        `FPCC_CNT_W'(SLOW_CYCLES - 1);

    // Counters are fixed width, so larger periods are refused.
    if (DEBOUNCE_CYCLES < 2 || DEBOUNCE_CYCLES > (1 << `FPCC_CNT_W) ||
        SLOW_CYCLES < 2 || SLOW_CYCLES > (1 << `FPCC_CNT_W))
    begin : g_bad_period
        $error("fpcc_top: timer period outside counter range");
    end

    fpcc_regs_s st;     // Registered state.
    fpcc_regs_s next_st; // Next state.
    logic       slowTick; // One cycle of the slow rate.

    // Every output is a field of the state register.
    assign regRdData    = st.regRdData;
    assign cpuHold      = st.cpuHold;
    assign cpuAdvance   = st.cpuAdvance;
    assign cpuReset     = st.cpuReset;
    assign busClear     = st.busClear;
    assign memAddr      = st.memAddr;
    assign memWrData    = st.memWrData;
    assign memRdStb     = st.memRdStb;
    assign memWrStb     = st.memWrStb;
    assign protectStb   = st.protectStb;
    assign unprotectStb = st.unprotectStb;
    assign accLoadStb   = st.accLoadStb;
    assign accLoadData  = st.accLoadData;
    assign ioInStb      = st.ioInStb;
    assign ioOutStb     = st.ioOutStb;
    assign ioPort       = st.ioPort;
    assign senseData    = st.senseData;
    assign senseValid   = st.senseValid;
    assign addrLamps    = st.addrLamps;
    assign dataLamps    = st.dataLamps;
    assign statusLamps  = st.statusLamps;

    // Next-state logic of the whole panel.
    always_comb
    begin
        next_st = st;
        slowTick = 1'b0;
        // Strobes last one cycle unless set below.
        next_st.cpuAdvance   = 1'b0;
        next_st.cpuReset     = 1'b0;
        next_st.memRdStb     = 1'b0;
        next_st.memWrStb     = 1'b0;
        next_st.protectStb   = 1'b0;
        next_st.unprotectStb = 1'b0;
        next_st.accLoadStb   = 1'b0;
        next_st.ioInStb      = 1'b0;
        next_st.ioOutStb     = 1'b0;
        next_st.senseValid   = 1'b0;
        next_st.regRdData    = 32'h0000_0000;
        next_st.cmd          = '0;

        // Two flip-flops on every switch pin; up reads as one.
        next_st.swSync1   = swIn;
        next_st.swSync2   = st.swSync1;
        next_st.addrSync1 = addrSwIn;
        next_st.addrSync2 = st.addrSync1;

        // Sampling at the debounce period outlasts contact
        // bounce, so each press rises exactly once.
        if (st.dbCnt == DB_LAST)
        begin
            next_st.dbCnt    = '0;
            next_st.swStable = st.swSync2;
            next_st.cmd      = fpcc_sw_s'(st.swSync2 & ~st.swStable);
        end
        else
        begin
            next_st.dbCnt = st.dbCnt + 1'b1;
        end

        // Slow rate timer runs only while slow is held.
        if (st.swStable.slow && st.state != PS_RUN)
        begin
            if (st.slowCnt == SLOW_LAST)
            begin
                next_st.slowCnt = '0;
                slowTick = 1'b1;
            end
            else
            begin
                next_st.slowCnt = st.slowCnt + 1'b1;
            end
        end
        else
        begin
            next_st.slowCnt = '0;
        end

        // First cycle after reset resets the processor.
        if (st.powerUp)
        begin
            next_st.powerUp  = 1'b0;
            next_st.cpuReset = 1'b1;
        end
        // Reset works in every state, run included.
        if (st.cmd.reset)
        begin
            next_st.cpuReset = 1'b1;
        end

        // Bus clear follows the held switch, not in run.
        next_st.busClear = st.swStable.busClearRequest && st.state != PS_RUN;

        case (st.state)
            PS_RUN:
            begin
                // Only stop leaves run; other commands but reset are dropped.
                if (st.cmd.stop)
                begin
                    next_st.state   = PS_STOP;
                    next_st.cpuHold = 1'b1;
                end
            end
            PS_STOP:
            begin
                // One command at a time, fixed priority.
                if (st.cmd.run)
                begin
                    next_st.state   = PS_RUN;
                    next_st.cpuHold = 1'b0;
                    next_st.showAcc = 1'b0;
                end
                else if (st.cmd.step)
                begin
                    next_st.state      = PS_ADVANCE;
                    next_st.cpuAdvance = 1'b1;
                end
                else if (st.cmd.examine)
                begin
                    next_st.memAddr  = st.addrSync2;
                    next_st.memRdStb = 1'b1;
                    next_st.state    = PS_READ;
                    next_st.showAcc  = 1'b0;
                end
                else if (st.cmd.examineFollowing)
                begin
                    next_st.memAddr  = st.memAddr + 16'h0001;
                    next_st.memRdStb = 1'b1;
                    next_st.state    = PS_READ;
                    next_st.showAcc  = 1'b0;
                end
                else if (st.cmd.deposit)
                begin
                    next_st.memWrData = st.addrSync2[7:0];
                    next_st.state     = PS_WRITE;
                    next_st.showAcc   = 1'b0;
                end
                else if (st.cmd.depositFollowing)
                begin
                    next_st.memAddr   = st.memAddr + 16'h0001;
                    next_st.memWrData = st.addrSync2[7:0];
                    next_st.state     = PS_WRITE;
                    next_st.showAcc   = 1'b0;
                end
                else if (st.cmd.protect)
                begin
                    next_st.protectStb = 1'b1;
                end
                else if (st.cmd.unprotect)
                begin
                    next_st.unprotectStb = 1'b1;
                end
                else if (st.cmd.accDisplay)
                begin
                    next_st.showAcc = 1'b1;
                end
                else if (st.cmd.accLoad)
                begin
                    next_st.accLoadStb  = 1'b1;
                    next_st.accLoadData = st.addrSync2[7:0];
                end
                else if (st.cmd.ioIn)
                begin
                    next_st.ioInStb = 1'b1;
                    next_st.ioPort  = st.addrSync2[15:8];
                end
                else if (st.cmd.ioOut)
                begin
                    next_st.ioOutStb = 1'b1;
                    next_st.ioPort   = st.addrSync2[15:8];
                end
                else if (slowTick)
                begin
                    next_st.state      = PS_ADVANCE;
                    next_st.cpuAdvance = 1'b1;
                end
            end
            PS_ADVANCE:
            begin
                // A boundary in the advance cycle is stale.
                if (cycleStart && !st.cpuAdvance)
                begin
                    if (!st.stepByInstr || cpuStatus.opcodeFetch)
                    begin
                        next_st.state = PS_STOP;
                    end
                    else
                    begin
                        next_st.cpuAdvance = 1'b1;
                    end
                end
            end
            PS_READ:
            begin
                // Memory answers the cycle after the strobe.
                next_st.state = PS_CAPTURE;
            end
            PS_CAPTURE:
            begin
                next_st.dataHold = memRdData;
                next_st.state    = PS_STOP;
            end
            PS_WRITE:
            begin
                // The board now sees the new address, so its
                // protect status is current for this write.
                if (!cpuStatus.memProtected)
                begin
                    next_st.memWrStb = 1'b1;
                    next_st.dataHold = st.memWrData;
                end
                next_st.state = PS_STOP;
            end
            default:
            begin
                next_st.state = PS_STOP;
            end
        endcase

        // Lamps follow the processor in run, the panel otherwise.
        if (st.state == PS_RUN)
        begin
            next_st.addrLamps = cpuAddr;
            next_st.dataLamps = cpuData;
        end
        else
        begin
            next_st.addrLamps = st.memAddr;
            next_st.dataLamps = st.showAcc ? accValue : st.dataHold;
        end
        next_st.statusLamps = cpuStatus;

        // Panel port answers with the upper switches.
        if (ioRdStb && ioRdPort == `FPCC_SENSE_PORT)
        begin
            next_st.senseValid = 1'b1;
            next_st.senseData  = st.addrSync2[15:8];
        end

        // Register port: write now, read data next cycle.
        if (regWr && regAddr == `FPCC_REG_CTRL)
        begin
            next_st.stepByInstr = regWrData[`FPCC_CTRL_INSTR_BIT];
        end
        if (regRd)
        begin
            case (regAddr)
                `FPCC_REG_CTRL:
                    next_st.regRdData[`FPCC_CTRL_INSTR_BIT] = st.stepByInstr;
                `FPCC_REG_STATUS:
                begin
                    next_st.regRdData[`FPCC_STAT_RUN_BIT]  = st.state == PS_RUN;
                    next_st.regRdData[`FPCC_STAT_BUSY_BIT] =
                        st.state != PS_RUN && st.state != PS_STOP;
                end
                `FPCC_REG_ADDR:
                    next_st.regRdData[15:0] = st.memAddr;
                default:
                    next_st.regRdData = 32'h0000_0000;
            endcase
        end
    end

    // State register; reset lands stopped with the processor held.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st             <= '0;
            st.state       <= PS_STOP;
            st.powerUp     <= 1'b1;
            st.cpuHold     <= 1'b1;
            st.memAddr     <= `FPCC_ADDR_RESET;
            st.stepByInstr <= `FPCC_CTRL_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Run mode issues no memory, accumulator, I/O or advance strobes.
    property p_run_quiet;
        @(posedge ref_clk) disable iff (!rst_n)
        st.state == PS_RUN |-> !(st.memRdStb || st.memWrStb ||
            st.accLoadStb || st.ioInStb || st.ioOutStb || st.cpuAdvance);
    endproperty
    a_run_quiet: assert property (p_run_quiet)
        else $error("panel strobe in run");

    // Stop keeps the processor held.
    property p_stop_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        st.state == PS_STOP |-> st.cpuHold && !st.cpuAdvance;
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("processor not held in stop");

    // An advance pulse is single and held around it.
    property p_step_once;
        @(posedge ref_clk) disable iff (!rst_n)
        st.cpuAdvance |-> st.cpuHold ##1 !st.cpuAdvance;
    endproperty
    a_step_once: assert property (p_step_once)
        else $error("advance pulse too long");

    // Examine reads the switch address and shows the byte.
    property p_examine;
        @(posedge ref_clk) disable iff (!rst_n)
        st.state == PS_STOP && $onehot(st.cmd) && st.cmd.examine
        |=> st.memRdStb && st.memAddr == $past(st.addrSync2)
        ##2 st.dataHold == $past(memRdData);
    endproperty
    a_examine: assert property (p_examine)
        else $error("examine failed");

    // Examine following advances the address by one.
    property p_examine_following;
        @(posedge ref_clk) disable iff (!rst_n)
        st.state == PS_STOP && $onehot(st.cmd) && st.cmd.examineFollowing
        |=> st.memRdStb && st.memAddr == $past(st.memAddr) + 16'h0001;
    endproperty
    a_examine_following: assert property (p_examine_following)
        else $error("examine following address wrong");

    // Deposit writes the low switches at the held address.
    property p_deposit;
        @(posedge ref_clk) disable iff (!rst_n)
        st.state == PS_STOP && $onehot(st.cmd) && st.cmd.deposit
        |=> st.memAddr == $past(st.memAddr) &&
            st.memWrData == $past(st.addrSync2[7:0]) && st.state == PS_WRITE;
    endproperty
    a_deposit: assert property (p_deposit)
        else $error("deposit data or address wrong");

    // No write strobe toward a protected board.
    property p_protect;
        @(posedge ref_clk) disable iff (!rst_n)
        st.memWrStb |-> !$past(cpuStatus.memProtected);
    endproperty
    a_protect: assert property (p_protect)
        else $error("write to protected memory");

    // Reset switch pulses the processor reset.
    property p_reset_sw;
        @(posedge ref_clk) disable iff (!rst_n)
        st.cmd.reset |=> st.cpuReset;
    endproperty
    a_reset_sw: assert property (p_reset_sw)
        else $error("reset switch ignored");

    // Panel port input returns the upper switches.
    property p_sense;
        @(posedge ref_clk) disable iff (!rst_n)
        ioRdStb && ioRdPort == `FPCC_SENSE_PORT
        |=> st.senseValid && st.senseData == $past(st.addrSync2[15:8]);
    endproperty
    a_sense: assert property (p_sense)
        else $error("sense data wrong");

    // Status lamps follow status lines one cycle later.
    property p_status;
        @(posedge ref_clk) disable iff (!rst_n)
        rst_n |=> st.statusLamps == $past(cpuStatus);
    endproperty
    a_status: assert property (p_status)
        else $error("status lamps stale");

    // First cycle after reset resets the processor, held.
    property p_power_up;
        @(posedge ref_clk) disable iff (!rst_n)
        rst_n && st.powerUp |=> st.cpuReset && st.cpuHold && st.memAddr == 16'h0000;
    endproperty
    a_power_up: assert property (p_power_up)
        else $error("power-up reset missing");

    // A command pulse lasts one cycle.
    property p_one_pulse;
        @(posedge ref_clk) disable iff (!rst_n)
        st.cmd != '0 |=> st.cmd == '0;
    endproperty
    a_one_pulse: assert property (p_one_pulse)
        else $error("command pulse too long");
endmodule
`default_nettype wire

/* File: tb/fpcc_mem_model.sv */
/*
 Memory board model on the far side of the panel.
 Assumes one-cycle panel strobes on ref_clk; the whole
 memory is one protectable board.
*/
`timescale 1ns/1ps
`default_nettype none
module fpcc_mem_model (
    input  wire logic        ref_clk,
    input  wire logic [15:0] memAddr,
    input  wire logic [7:0]  memWrData,
    input  wire logic        memRdStb,
    input  wire logic        memWrStb,
    input  wire logic        protectStb,
    input  wire logic        unprotectStb,
    output var logic  [7:0]  memRdData,
    output var logic         memProtected
);
    logic [7:0] mem [0:65535]; // Board contents.
    // Preload a pattern the bench can recompute from the address.
    initial
    begin
        for (int i = 0; i < 65536; i++)
            mem[i] = 8'(i ^ (i >> 8));
        memProtected = 1'b0;
        memRdData = 8'h00;
    end
    // Read data stands one cycle only; after that the lines toggle.
    always @(posedge ref_clk)
    begin
        if (memWrStb && !memProtected)
            mem[memAddr] <= memWrData;
        if (protectStb)
            memProtected <= 1'b1;
        if (unprotectStb)
            memProtected <= 1'b0;
        memRdData <= memRdStb ? mem[memAddr] : ~memRdData;
    end
endmodule
`default_nettype wire

/* File: tb/fpcc_top_tb.sv */
/*
 Self-checking bench for the panel controller.
 Assumes short debounce and slow counts set below.
*/
`timescale 1ns/1ps
`default_nettype none
module fpcc_top_tb;
    import fpcc_pkg::*;
    logic ref_clk, rst_n, cycleStart, ioRdStb, regWr, regRd, memProt, cpuHold, cpuAdvance, cpuReset;
    logic memRdStb, memWrStb, protectStb, unprotectStb, senseValid, accLoadStb, ioInStb, ioOutStb, busClear;
    logic [7:0] ioRdPort, regAddr, cpuData, accValue, memRdData, memWrData, accLoadData, ioPort, senseData;
    logic [7:0] dataLamps;
    logic [15:0] addrSwIn, cpuAddr, memAddr, addrLamps, a, b;
    logic [31:0] regWrData, regRdData, q, r;
    logic [11:1] statDrv;
    fpcc_sw_s swIn;
    fpcc_status_s statusLamps;
    wire fpcc_status_s cpuStatus = {statDrv, memProt};
    int err_total, checks, advCnt, rstCnt, seed, refMem[int], stbCnt, clrCnt;
    fpcc_top #(.DEBOUNCE_CYCLES(4), .SLOW_CYCLES(20)) u_dut (.ref_clk, .rst_n, .swIn, .addrSwIn, .cpuStatus,
        .cycleStart, .cpuAddr, .cpuData, .accValue, .ioRdStb, .ioRdPort, .memRdData, .regAddr, .regWrData,
        .regWr, .regRd, .regRdData, .cpuHold, .cpuAdvance, .cpuReset, .busClear, .memAddr, .memWrData,
        .memRdStb, .memWrStb, .protectStb, .unprotectStb, .accLoadStb, .accLoadData, .ioInStb,
        .ioOutStb, .ioPort, .senseData, .senseValid, .addrLamps, .dataLamps, .statusLamps);
    fpcc_mem_model u_mem (.ref_clk, .memAddr, .memWrData, .memRdStb, .memWrStb, .protectStb, .unprotectStb,
        .memRdData, .memProtected(memProt));
    // Expected byte: a written value, else the preload pattern.
    function automatic int rd(input int ad);
        return refMem.exists(ad) ? refMem[ad] : ((ad ^ (ad >> 8)) & 255);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Hold long enough for two debounce samples each way.
    task automatic press(input int s, input logic [15:0] v);
        @(posedge ref_clk);
        swIn[s] <= 1'b1;
        addrSwIn <= v;
        repeat (14) @(posedge ref_clk);
        swIn[s] <= 1'b0;
        repeat (14) @(posedge ref_clk);
        #1;
    endtask
    // One register access; read data is taken in the following cycle.
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge ref_clk);
        regAddr <= ad;
        regWrData <= d;
        regWr <= w;
        regRd <= !w;
        @(posedge ref_clk);
        regWr <= 1'b0;
        regRd <= 1'b0;
        #1 r = regRdData;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // Pulse counters for processor control strobes.
    always @(posedge ref_clk)
    begin
        advCnt += int'(cpuAdvance);
        rstCnt += int'(cpuReset);
        stbCnt += int'(accLoadStb) + int'(ioInStb) + int'(ioOutStb);
        clrCnt += int'(busClear);
    end
    // Cuts a hang short after more than ten times the expected run length.
    initial
    begin
        #400000;
        err_total++;
        give_verdict();
    end
    initial
    begin
        seed = 32'h43d5826d;
        {swIn, addrSwIn, cycleStart, ioRdStb, regWr, regRd, regAddr, regWrData, ioRdPort, statDrv} = '0;
        cpuAddr = 16'($random(seed));
        cpuData = 8'($random(seed));
        accValue = 8'($random(seed));
        rst_n = 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1 chk(cpuHold, 1);
        chk(rstCnt, 1);
        a = 16'($random(seed));
        b = a + 16'd1;
        q = $random(seed);
        press(11, a);
        chk(addrLamps, a);
        chk(dataLamps, rd(a));
        press(9, q[15:0]);
        refMem[a] = q[7:0];
        chk(dataLamps, q[7:0]);
        press(8, q[31:16]);
        refMem[b] = q[23:16];
        chk(memAddr, b);
        press(11, a);
        chk(dataLamps, rd(a));
        press(10, a);
        chk(dataLamps, rd(b));
        $display("memory tests done");
        press(5, b);
        chk(statusLamps.memProtected, 1);
        press(9, ~q[15:0]);
        press(11, b);
        chk(dataLamps, rd(b));
        press(4, b);
        press(9, ~q[15:0]);
        refMem[b] = ~q[7:0] & 255;
        press(11, b);
        chk(dataLamps, rd(b));
        press(6, b);
        chk(clrCnt inside {12, 16}, 1);
        $display("protect tests done");
        press(3, q[15:0]);
        chk(dataLamps, accValue);
        press(2, q[15:0]);
        chk(accLoadData, q[7:0]);
        press(1, q[31:16]);
        chk(ioPort, q[31:24]);
        press(0, q[15:0]);
        chk(ioPort, q[15:8]);
        chk(stbCnt, 3);
        @(posedge ref_clk);
        ioRdStb <= 1'b1;
        ioRdPort <= 8'hFF;
        @(posedge ref_clk);
        ioRdStb <= 1'b0;
        #1 chk(senseValid, 1);
        chk(senseData, q[15:8]);
        $display("accumulator tests done");
        advCnt = 0;
        press(13, b);
        @(posedge ref_clk);
        cycleStart <= 1'b1;
        @(posedge ref_clk);
        cycleStart <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk(advCnt, 1);
        chk(cpuHold, 1);
        cycleStart <= 1'b1;
        swIn.slow <= 1'b1;
        repeat (200) @(posedge ref_clk);
        swIn.slow <= 1'b0;
        repeat (20) @(posedge ref_clk);
        cycleStart <= 1'b0;
        #1 chk(advCnt, 11);
        bus(0, 8'h08, 0);
        chk(r, b);
        bus(1, 8'h00, 1);
        bus(0, 8'h00, 0);
        chk(r, 1);
        bus(0, 8'h0C, 0);
        chk(r, 0);
        advCnt = 0;
        press(13, b);
        repeat (2)
        begin
            @(posedge ref_clk);
            cycleStart <= 1'b1;
            @(posedge ref_clk);
            cycleStart <= 1'b0;
            statDrv[10] <= 1'b1;
        end
        bus(0, 8'h04, 0);
        chk(r, 0);
        chk(advCnt, 2);
        @(posedge ref_clk);
        statDrv <= 11'($random(seed));
        repeat (3) @(posedge ref_clk);
        #1 chk(statusLamps, cpuStatus);
        $display("step and register tests done");
        press(15, b);
        chk(cpuHold, 0);
        bus(0, 8'h04, 0);
        chk(r, 1);
        press(11, ~b);
        chk(memAddr, b);
        press(7, b);
        chk(rstCnt, 2);
        press(14, b);
        chk(cpuHold, 1);
        $display("run tests done");
        give_verdict();
    end
endmodule
`default_nettype wire
